/* rtl/mirc_top.v */
// Station control data set interface and reverse channel logic
//
// Contract
// - Pin inputs and outputs carry EIA sense: 1 means positive/on, 0 negative/off.
// - Ring indicator inactive keeps terminal-ready asserted.
// - Ring indicator active drops terminal-ready; answering is manual.
// - Data-set-ready on sets the internal ready flag.
// - Ready flag off holds punch-blind asserted low.
// - Receive clock is synchronised and forwarded as a neutral level.
// - Receive data is synchronised and passed unchanged to the distributor.
// - Carrier feeds punch blind; carrier indication updates only while ready.
// - Remote-halt indicator lit while carrier absent, off while present.
// - Reverse-channel output high requests, low withdraws the request.
// - Request only when all inhibits inactive; any inhibit holds it off.
// - Stop or hold latch set holds the request off.
// - With latches clear, error-check module line controls the request.
// - Accessory inhibit input also holds the request off.
// - Punch-blind combination active holds the request off.
// - Test position forces ready and stops carrier affecting punch blind.
// - Any module alarm asserts common alarm, setting stop and hold latches.
`default_nettype none
`include "mirc_defines.vh"
module mirc_top
(
  // Clock and reset
  input wire CLK_SYS,
  input wire SRST,
  // Data set control pins, 1 = on
  input wire RING_IND,
  input wire DSET_READY,
  input wire CARRIER_DET,
  output wire TERM_READY,
  output wire REV_CHAN_REQ,
  // Data set stream pins
  input wire RX_CLK,
  input wire RX_DATA,
  // Terminal side stream
  output wire RX_CLK_OUT,
  output wire RX_DATA_OUT,
  output wire RX_BIT_VALID,
  output wire RX_BIT_DATA,
  input wire RX_BIT_READY,
  // Operator and module inputs
  input wire TEST_OPERATE_SELECTOR,
  input wire STOP_RESET_BUTTON,
  input wire ERROR_CHECK_MODULE_RC_ON,
  input wire ACCESSORY_INHIBIT,
  input wire FEED_ALARM,
  input wire BACKUP_ALARM,
  input wire PUNCH_VERIFY_ALARM,
  // Status outputs
  output wire READY,
  output wire PUNCH_BLIND_N,
  output wire CARRIER_IND,
  output wire REMOTE_HALT,
  output wire COMMON_ALARM,
  output wire STOP_LATCH,
  output wire HOLD_LATCH
);
  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  wire ri_s;
  wire dsr_s;
  wire cd_s;
  wire rxc_s;
  wire rxd_s;
  wire test_s;
  wire btn_s;
  wire ec_s;
  wire acc_s;
  wire fa_s;
  wire ba_s;
  wire pa_s;
  mirc_sync u_sync_ri
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(RING_IND),
    .dout(ri_s)
  );
  mirc_sync u_sync_dsr
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(DSET_READY),
    .dout(dsr_s)
  );
  mirc_sync u_sync_cd
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(CARRIER_DET),
    .dout(cd_s)
  );
  mirc_sync u_sync_rxc
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(RX_CLK),
    .dout(rxc_s)
  );
  mirc_sync u_sync_rxd
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(RX_DATA),
    .dout(rxd_s)
  );
  mirc_sync u_sync_test
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(TEST_OPERATE_SELECTOR),
    .dout(test_s)
  );
  mirc_sync u_sync_btn
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(STOP_RESET_BUTTON),
    .dout(btn_s)
  );
  mirc_sync u_sync_ec
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(ERROR_CHECK_MODULE_RC_ON),
    .dout(ec_s)
  );
  mirc_sync u_sync_acc
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(ACCESSORY_INHIBIT),
    .dout(acc_s)
  );
  mirc_sync u_sync_fa
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(FEED_ALARM),
    .dout(fa_s)
  );
  mirc_sync u_sync_ba
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(BACKUP_ALARM),
    .dout(ba_s)
  );
  mirc_sync u_sync_pa
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .din(PUNCH_VERIFY_ALARM),
    .dout(pa_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Relay registers
  reg dtr_q;
  reg ready_q;
  reg blind_n_q;
  reg cd_ind_q;
  reg halt_q;
  reg alarm_q;
  reg stop_q;
  reg hold_q;
  reg btn_prev_q;
  reg rc_q;
  reg rxc_q;
  reg rxd_q;
  reg rxc_prev_q;
  reg bit_valid_q;
  reg bit_data_q;
  wire ready_d;
  wire blind_act;
  wire alarm_d;
  wire btn_rise;
  wire btn_fall;
  wire [`MIRC_INH_W-1:0] inhibit;
  wire rc_d;

  assign ready_d = dsr_s | test_s;
  assign blind_act = ~ready_q | (~cd_s & ~test_s);
  assign alarm_d = fa_s | ba_s | pa_s;
  assign btn_rise = btn_s & ~btn_prev_q;
  assign btn_fall = ~btn_s & btn_prev_q;

  assign inhibit[`MIRC_INH_LATCH] = stop_q | hold_q;
  assign inhibit[`MIRC_INH_ERRCHK] = ~ec_s;
  assign inhibit[`MIRC_INH_ACC] = acc_s;
  assign inhibit[`MIRC_INH_BLIND] = blind_act;
  assign rc_d = ~(|inhibit);

  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      dtr_q <= `MIRC_RST_TERM_READY;
      ready_q <= `MIRC_RST_READY;
      blind_n_q <= `MIRC_RST_BLIND_N;
      cd_ind_q <= `MIRC_RST_CARRIER;
      halt_q <= `MIRC_RST_HALT;
      alarm_q <= `MIRC_RST_ALARM;
      stop_q <= `MIRC_RST_STOP;
      hold_q <= `MIRC_RST_HOLD;
      btn_prev_q <= 1'h0;
      rc_q <= `MIRC_RST_REVCH;
    end
    else
    begin
      dtr_q <= ~ri_s;
      ready_q <= ready_d;
      blind_n_q <= ~blind_act;
      if (ready_q)
        cd_ind_q <= cd_s;
      halt_q <= ~cd_s;
      alarm_q <= alarm_d;
      btn_prev_q <= btn_s;
      if (alarm_q)
      begin
        stop_q <= 1'h1;
        hold_q <= 1'h1;
      end
      else if (!ready_q)
      begin
        // No call: stop only while pressed
        stop_q <= btn_s;
        hold_q <= btn_s;
      end
      else
      begin
        // Call in progress: press sets, second press clears stop, release clears hold
        if (btn_rise && !hold_q)
        begin
          stop_q <= 1'h1;
          hold_q <= 1'h1;
        end
        else if (btn_rise && hold_q)
          stop_q <= 1'h0;
        else if (btn_fall && !stop_q)
          hold_q <= 1'h0;
      end
      rc_q <= rc_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive stream
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_out_data;
  wire rxc_rise;
  assign rxc_rise = rxc_s & ~rxc_prev_q;

  always @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      rxc_q <= 1'h0;
      rxd_q <= 1'h0;
      rxc_prev_q <= 1'h0;
      bit_valid_q <= 1'h0;
      bit_data_q <= 1'h0;
    end
    else
    begin
      rxc_q <= rxc_s;
      rxd_q <= rxd_s;
      rxc_prev_q <= rxc_s;
      if (!bit_valid_q || RX_BIT_READY)
      begin
        bit_valid_q <= buf_out_valid;
        if (buf_out_valid)
          bit_data_q <= buf_out_data;
      end
    end
  end

  mirc_buf u_buf
  (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_valid(rxc_rise),
    .in_ready(buf_in_ready),
    .in_data(rxd_s),
    .out_valid(buf_out_valid),
    .out_ready(!bit_valid_q || RX_BIT_READY),
    .out_data(buf_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  // EIA sense on pins
  assign TERM_READY = dtr_q;
  assign REV_CHAN_REQ = rc_q;
  assign RX_CLK_OUT = rxc_q;
  assign RX_DATA_OUT = rxd_q;
  assign RX_BIT_VALID = bit_valid_q;
  assign RX_BIT_DATA = bit_data_q;
  assign READY = ready_q;
  assign PUNCH_BLIND_N = blind_n_q;
  assign CARRIER_IND = cd_ind_q;
  assign REMOTE_HALT = halt_q;
  assign COMMON_ALARM = alarm_q;
  assign STOP_LATCH = stop_q;
  assign HOLD_LATCH = hold_q;
endmodule
`default_nettype wire

/* rtl/mirc_defines.vh */
// Shared constants for the modem interface and reverse channel block
`ifndef MIRC_DEFINES_VH
`define MIRC_DEFINES_VH
// Synchroniser depth
`define MIRC_SYNC_STAGES 2
// Reset levels of the relay registers
`define MIRC_RST_READY 1'h0
`define MIRC_RST_STOP 1'h0
`define MIRC_RST_HOLD 1'h0
`define MIRC_RST_REVCH 1'h0
`define MIRC_RST_TERM_READY 1'h1
`define MIRC_RST_BLIND_N 1'h0
`define MIRC_RST_CARRIER 1'h0
`define MIRC_RST_HALT 1'h1
`define MIRC_RST_ALARM 1'h0
// Buffer depth and pointer width
`define MIRC_BUF_DEPTH 2
`define MIRC_BUF_PW 1
// Positions of the inhibit word
`define MIRC_INH_LATCH 0
`define MIRC_INH_ERRCHK 1
`define MIRC_INH_ACC 2
`define MIRC_INH_BLIND 3
`define MIRC_INH_W 4
`endif

/* rtl/mirc_sync.v */
// Two-flip-flop synchroniser for one asynchronous level
`default_nettype none
module mirc_sync
(
  // Clock and reset
  input wire clk,
  input wire srst,
  // Level
  input wire din,
  output wire dout
);
  reg s1_q;
  reg s2_q;
  always @(posedge clk)
  begin
    if (srst)
    begin
      s1_q <= 1'h0;
      s2_q <= 1'h0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule
`default_nettype wire

/* rtl/mirc_buf.v */
// Two-entry valid/ready buffer for received data bits
`default_nettype none
`include "mirc_defines.vh"
module mirc_buf
(
  // Clock and reset
  input wire clk,
  input wire srst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire out_data
);
  reg [`MIRC_BUF_DEPTH-1:0] mem_q;
  reg [`MIRC_BUF_PW-1:0] wp_q;
  reg [`MIRC_BUF_PW-1:0] rp_q;
  reg [`MIRC_BUF_PW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk)
  begin
    if (srst)
    begin
      mem_q <= 2'h0;
      wp_q <= 1'h0;
      rp_q <= 1'h0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q <= wp_q + 1'h1;
      end
      if (pop)
        rp_q <= rp_q + 1'h1;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/mirc_checker.sv */
// Concurrent checks on the data set interface block ports
`default_nettype none
module mirc_checker (
  input wire logic CLK_SYS, SRST, RING_IND, DSET_READY, CARRIER_DET, RX_CLK, RX_DATA, TEST_OPERATE_SELECTOR,
  input wire logic ERROR_CHECK_MODULE_RC_ON, ACCESSORY_INHIBIT, FEED_ALARM, BACKUP_ALARM, PUNCH_VERIFY_ALARM,
  input wire logic RX_BIT_READY, TERM_READY, REV_CHAN_REQ, RX_CLK_OUT, RX_BIT_VALID, RX_BIT_DATA, READY,
  input wire logic PUNCH_BLIND_N, CARRIER_IND, REMOTE_HALT, COMMON_ALARM, STOP_LATCH, HOLD_LATCH, RX_DATA_OUT
);
  logic [2:0] up_q;
  wire logic ok = up_q == 3'h7;
  // Cycles since reset release, so that $past sees no reset values
  always_ff @(posedge CLK_SYS) up_q <= SRST ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  a_term_ready: assert property (ok |-> TERM_READY == !$past(RING_IND, 3)) else $error("term ready bad");
  a_ready_flag: assert property (ok |-> READY == $past(DSET_READY || TEST_OPERATE_SELECTOR, 3))
    else $error("ready bad");
  a_rx_clock: assert property (ok |-> RX_CLK_OUT == $past(RX_CLK, 3)) else $error("rx clock bad");
  a_rx_data: assert property (ok |-> RX_DATA_OUT == $past(RX_DATA, 3)) else $error("rx data bad");
  a_remote_halt: assert property (ok |-> REMOTE_HALT == !$past(CARRIER_DET, 3)) else $error("halt bad");
  a_alarm_or: assert property (ok |-> COMMON_ALARM == $past(FEED_ALARM || BACKUP_ALARM || PUNCH_VERIFY_ALARM, 3))
    else $error("alarm bad");
  a_blind_ready: assert property (!READY |=> !PUNCH_BLIND_N) else $error("not blinded");
  a_carrier_hold: assert property (!READY |=> $stable(CARRIER_IND)) else $error("carrier moved");
  a_alarm_latch: assert property (COMMON_ALARM |=> STOP_LATCH && HOLD_LATCH) else $error("latch bad");
  a_rev_equation: assert property (ok |-> REV_CHAN_REQ == (PUNCH_BLIND_N && !$past(STOP_LATCH) &&
    !$past(HOLD_LATCH) && $past(ERROR_CHECK_MODULE_RC_ON, 3) && !$past(ACCESSORY_INHIBIT, 3))) else $error("rev bad");
  a_bit_hold: assert property (RX_BIT_VALID && !RX_BIT_READY |=> RX_BIT_VALID && $stable(RX_BIT_DATA))
    else $error("bit lost");
  c_rev_on: cover property (REV_CHAN_REQ);
  c_latched: cover property (STOP_LATCH && HOLD_LATCH);
  c_bit_stall: cover property (RX_BIT_VALID && !RX_BIT_READY);
endmodule
`default_nettype wire

/* tb/mirc_dset_model.sv */
// Behavioural data set facing the interface block
`default_nettype none
module mirc_dset_model (
  input wire logic term_ready,
  input wire logic rev_chan_req,
  output var logic ring_ind,
  output var logic dset_ready,
  output var logic carrier_det,
  output var logic rx_clk,
  output var logic rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {ring_ind, dset_ready, carrier_det, rx_clk, rx_data} = 5'h0;
  wire logic rev_sending = rev_chan_req;
  // data mode only with terminal ready
  task answer;
    dset_ready <= term_ready;
    carrier_det <= term_ready;
  endtask
  // Clock runs only within a frame, line then inverted
  task send_byte(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--)
    begin
      rx_data = b[i];
      #160 rx_clk = 1'b1;
      #160 rx_clk = 1'b0;
    end
    rx_data = ~rx_data;
  endtask
endmodule
`default_nettype wire

/* tb/mirc_top_tb.sv */
// Self-checking bench for the data set interface block
`default_nettype none
module mirc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, tst = 0, btn = 0, ec = 0, acc = 0, rdy = 0;
  logic [2:0] alm = 3'h0;
  logic [7:0] got = 8'h00;
  int fails = 0, compares = 0, cyc = 0, n = 0;
  wire logic ri, dsr, cd, rxc, rxd, dtr, rev, rco, rdo, bv, bd, ro, pbn, ci, rh, ca, sl, hl;
  always #20 clk = ~clk;
  mirc_dset_model ds_u (.term_ready(dtr), .rev_chan_req(rev), .ring_ind(ri), .dset_ready(dsr),
    .carrier_det(cd), .rx_clk(rxc), .rx_data(rxd));
  mirc_top dut_u (.CLK_SYS(clk), .SRST(srst), .RING_IND(ri), .DSET_READY(dsr), .CARRIER_DET(cd),
    .TERM_READY(dtr), .REV_CHAN_REQ(rev), .RX_CLK(rxc), .RX_DATA(rxd), .RX_CLK_OUT(rco), .RX_DATA_OUT(rdo),
    .RX_BIT_VALID(bv), .RX_BIT_DATA(bd), .RX_BIT_READY(rdy), .TEST_OPERATE_SELECTOR(tst),
    .STOP_RESET_BUTTON(btn), .ERROR_CHECK_MODULE_RC_ON(ec), .ACCESSORY_INHIBIT(acc), .FEED_ALARM(alm[0]),
    .BACKUP_ALARM(alm[1]), .PUNCH_VERIFY_ALARM(alm[2]), .READY(ro), .PUNCH_BLIND_N(pbn), .CARRIER_IND(ci),
    .REMOTE_HALT(rh), .COMMON_ALARM(ca), .STOP_LATCH(sl), .HOLD_LATCH(hl));
  task step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Collects delivered bits, oldest highest
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      give_verdict;
    end
    if (bv === 1'b1 && rdy)
    begin
      got <= {got[6:0], bd};
      n <= n + 1;
    end
  end
  initial
  begin
    step(5);
    srst <= 0;
    step(1);
    chk("dtr", dtr, 1);
    chk("halt", rh, 1);
    chk("blind", pbn, 0);
    ds_u.ring_ind <= 1;
    step(6);
    chk("dtr ring", dtr, 0);
    ds_u.answer();
    ds_u.ring_ind <= 0;
    step(6);
    chk("dsr ring", dsr, 0);
    ds_u.answer();
    ec <= 1;
    step(6);
    chk("ready", {ro, ci, rh, rev}, 4'hd);
    $display("test answer done");
    for (int i = 0; i < 5; i++)
    begin
      if (i < 3) alm[i] <= 1;
      else if (i == 3) acc <= 1;
      else ec <= 0;
      step(6);
      chk("rev inhibit", rev, 0);
      if (i < 3) chk("latches", {sl, hl, ca}, 3'h7);
      alm <= 3'h0;
      acc <= 0;
      ec <= 1;
      step(6);
      if (i < 3)
      begin
        chk("rev latched", rev, 0);
        btn <= 1;
        step(6);
        btn <= 0;
        step(6);
      end
      chk("rev back", rev, 1);
    end
    btn <= 1;
    step(6);
    chk("stop press", {sl, hl, rev}, 3'h6);
    btn <= 0;
    step(6);
    chk("stop held", {sl, hl, rev}, 3'h6);
    btn <= 1;
    step(6);
    btn <= 0;
    step(6);
    chk("stop cleared", {sl, hl, rev}, 3'h1);
    $display("test inhibits done");
    ds_u.carrier_det <= 0;
    step(6);
    chk("carrier lost", {rev, pbn, rh, ci}, 4'h2);
    tst <= 1;
    step(6);
    chk("test pos", {rev, pbn}, 2'h3);
    ds_u.dset_ready <= 0;
    step(6);
    chk("test ready", ro, 1);
    tst <= 0;
    step(6);
    chk("hung up", {ro, pbn, rev}, 3'h0);
    ds_u.carrier_det <= 1;
    step(6);
    chk("cind held", ci, 0);
    btn <= 1;
    step(6);
    chk("idle stop", {sl, hl, rev}, 3'h6);
    btn <= 0;
    step(6);
    chk("idle free", {sl, hl, rev}, 3'h0);
    $display("test blind done");
    ds_u.send_byte(8'ha5);
    step(4);
    chk("stall", {bv, bd}, 2'h3);
    rdy <= 1;
    step(8);
    chk("kept", n, 3);
    chk("kept bits", got[2:0], 3'h5);
    n = 0;
    ds_u.send_byte(8'h3c);
    step(6);
    chk("count", n, 8);
    chk("byte", got, 8'h3c);
    $display("test stream done");
    give_verdict;
  end
endmodule
bind mirc_top mirc_checker chk_u (.CLK_SYS, .SRST, .RING_IND, .DSET_READY, .CARRIER_DET, .RX_CLK,
  .TEST_OPERATE_SELECTOR, .ERROR_CHECK_MODULE_RC_ON, .ACCESSORY_INHIBIT, .FEED_ALARM, .BACKUP_ALARM,
  .PUNCH_VERIFY_ALARM, .RX_BIT_READY, .TERM_READY, .REV_CHAN_REQ, .RX_CLK_OUT, .RX_BIT_VALID, .RX_BIT_DATA,
  .READY, .PUNCH_BLIND_N, .CARRIER_IND, .REMOTE_HALT, .COMMON_ALARM, .STOP_LATCH, .HOLD_LATCH, .RX_DATA,
  .RX_DATA_OUT);
`default_nettype wire
